/* File: pll_pkg.sv */
// package: register map, reset values, timing constants and carriers
// assumes a single 20 MHz system clock shared by every design file
package pll_pkg;

  localparam int          CLK_HZ       = 20_000_000;
  localparam int          AW           = 4;
  localparam int          DW           = 16;

  // register offsets, one register per address
  localparam logic [3:0]  OFF_CTRL     = 4'h0;
  localparam logic [3:0]  OFF_MDIV     = 4'h1;
  localparam logic [3:0]  OFF_NDIV     = 4'h2;
  localparam logic [3:0]  OFF_QUAL     = 4'h3;
  localparam logic [3:0]  OFF_FILT     = 4'h4;
  localparam logic [3:0]  OFF_VDIV0    = 4'h5;
  localparam logic [3:0]  OFF_STAT     = 4'hA;

  // field positions
  localparam int          CTRL_FREQ_B  = 0;
  localparam int          CTRL_COARSE_B = 1;
  localparam int          CTRL_FBSEL_LO = 2;
  localparam int          FILT_RES_LO  = 4;
  localparam int          VDIV_SKEW_LO = 8;

  // reset values (ratio fields hold ratio-1, output fields hold ratio/2-1)
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [4:0]  MDIV_RST     = 5'h00;
  localparam logic [4:0]  NDIV_RST     = 5'h00;
  localparam logic [7:0]  QUAL_RST     = 8'h0F;
  localparam logic [7:0]  QUAL_MIN     = 8'h0F;
  localparam logic [3:0]  ICP_RST      = 4'h0;
  localparam logic [3:0]  ICP_MAX      = 4'hD;
  localparam logic [2:0]  RES_RST      = 3'h0;
  localparam logic [2:0]  RES_MAX      = 3'h5;
  localparam logic [4:0]  VDIV_RST     = 5'h00;
  localparam logic [2:0]  FBSEL_MAX    = 3'h4;

  // times and the cycle counts derived from them
  localparam int          PHASE_WIN_NS = 100;
  localparam int          PHASE_WIN_CYC = (PHASE_WIN_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int          REF_LOSS_NS  = 10_000;
  localparam int          REF_LOSS_CYC = (REF_LOSS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef struct packed {
    logic       freq_mode;
    logic       enable;
    logic [7:0] qual_m1;
  } lock_cfg_t;

  typedef struct packed {
    logic       locked;
    logic       ref_lost;
  } lock_stat_t;

endpackage

/* File: edge_div.sv */
// event divider: counts input event pulses, emits a terminal pulse and a level
// assumes event pulses are one clock wide and come from logic on the same clock
module edge_div #(
  parameter int W  = 5,
  parameter int DLW = 6
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // control
  input  wire logic           sync_clr,
  input  wire logic [W-1:0]   ratio_m1,
  input  wire logic [DLW-1:0] start_dly,
  // events
  input  wire logic           ev,
  output logic                tc,
  output logic                lvl
);

  logic [W-1:0]   cnt_r;
  logic [DLW-1:0] dly_r;

  // a common clear holds every divider so all restart edge aligned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      dly_r <= '0;
      tc    <= 1'b0;
      lvl   <= 1'b0;
    end else if (sync_clr) begin
      cnt_r <= '0;
      dly_r <= start_dly;
      tc    <= 1'b0;
      lvl   <= 1'b0;
    end else begin
      tc <= 1'b0;
      if (ev) begin
        if (dly_r != '0) begin
          dly_r <= dly_r - 1'b1;
        end else if (cnt_r == ratio_m1) begin
          cnt_r <= '0;
          tc    <= 1'b1;
          lvl   <= ~lvl;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule

/* File: lock_det.sv */
// lock detector: compares prescaled reference and feedback event pulses
// assumes both event streams are one-cycle pulses on the system clock
module lock_det (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // configuration
  input  wire pll_pkg::lock_cfg_t  cfg,
  // detector events
  input  wire logic                ref_ev,
  input  wire logic                fb_ev,
  // result
  output pll_pkg::lock_stat_t      stat
);

  localparam logic [7:0]  WIN  = 8'(pll_pkg::PHASE_WIN_CYC);
  localparam logic [15:0] LOSS = 16'(pll_pkg::REF_LOSS_CYC);

  logic [7:0]  ref_age_r;
  logic [7:0]  fb_age_r;
  logic [15:0] loss_cnt_r;
  logic [1:0]  fb_cnt_r;
  logic        hit_r;
  logic [8:0]  qual_cnt_r;
  logic        locked_r;
  logic        hit_now;
  logic        cond;
  logic        lost;

  assign hit_now = (ref_ev && fb_age_r <= WIN) || (fb_ev && ref_age_r <= WIN);
  assign lost    = (loss_cnt_r >= LOSS);
  // frequency match: exactly one feedback event per reference period
  assign cond    = (fb_cnt_r + {1'b0, fb_ev} == 2'd1) &&
                   (cfg.freq_mode || hit_r || hit_now);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_age_r <= 8'hFF;
      fb_age_r  <= 8'hFF;
    end else begin
      ref_age_r <= ref_ev ? 8'h00 : (ref_age_r == 8'hFF ? ref_age_r : ref_age_r + 1'b1);
      fb_age_r  <= fb_ev  ? 8'h00 : (fb_age_r  == 8'hFF ? fb_age_r  : fb_age_r  + 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loss_cnt_r <= '0;
    end else if (ref_ev) begin
      loss_cnt_r <= '0;
    end else if (!lost) begin
      loss_cnt_r <= loss_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_cnt_r <= '0;
      hit_r    <= 1'b0;
    end else if (ref_ev) begin
      fb_cnt_r <= '0;
      hit_r    <= 1'b0;
    end else begin
      if (fb_ev && fb_cnt_r != 2'd3) begin
        fb_cnt_r <= fb_cnt_r + 1'b1;
      end
      if (hit_now) begin
        hit_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qual_cnt_r <= '0;
      locked_r   <= 1'b0;
    end else if (!cfg.enable) begin
      qual_cnt_r <= '0;
      locked_r   <= 1'b0;
    end else if (!cfg.freq_mode && lost) begin
      qual_cnt_r <= '0;
      locked_r   <= 1'b0;
    // frequency mode judges only at reference pulses
    end else if (!cfg.freq_mode && (fb_cnt_r == 2'd2 || (fb_ev && fb_cnt_r == 2'd1))) begin
      qual_cnt_r <= '0;
      locked_r   <= 1'b0;
    end else if (ref_ev) begin
      if (!cond) begin
        qual_cnt_r <= '0;
        locked_r   <= 1'b0;
      end else if (!cfg.freq_mode) begin
        locked_r <= 1'b1;
      end else begin
        if (qual_cnt_r != 9'h100) begin
          qual_cnt_r <= qual_cnt_r + 1'b1;
        end
        locked_r <= (qual_cnt_r >= {1'b0, cfg.qual_m1});
      end
    end
    // a stopped reference never ends a frequency-mode period, so lock is kept
  end

  assign stat.locked   = locked_r;
  assign stat.ref_lost = lost;

endmodule

/* File: pll_divider_lock_detect.sv */
// top: digital side of a clock synthesis loop, dividers, lock detect, registers
// assumes reference and oscillator come in as pins sampled on CLK; the analog
// charge pump and filter take CP_SEL and RES_SEL, and this block never sees them
//
// What this block does
// - lock output low while locked
// - selectable phase or frequency lock mode
// - phase mode locks with no delay
// - frequency mode qualifies 16 to 256 cycles
// - lock loss deasserts output at once
// - phase mode reference loss drops lock
// - frequency mode may hold lock without reference
// - current 14 settings, resistor six settings
// - reference prescale 1 to 32
// - feedback prescale 1 to 32
// - five output dividers, even 2 to 64
// - feedback taken from any output divider
// - output equals ref times N*Vfb over M*Vk
// - skew steps counted in oscillator periods
// - bypass feeds prescaled reference to dividers
// - bypass halves output divider ratios
// - bypass disables lock and skew
//
// Implementation choices: the strobed register port and the address map.
module pll_divider_lock_detect #(
  parameter int NOUT = 5
) (
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST,
  // register port
  input  wire logic [pll_pkg::AW-1:0]  ADDR,
  input  wire logic [pll_pkg::DW-1:0]  WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output logic [pll_pkg::DW-1:0]       RDATA,
  // clock pins
  input  wire logic                    REF_CLK,
  input  wire logic                    VCO_CLK,
  input  wire logic                    BYPASS,
  // outputs
  output logic [NOUT-1:0]              CLK_OUT,
  output logic                         LOCK_N,
  output logic [3:0]                   CP_SEL,
  output logic [2:0]                   RES_SEL
);

  logic [2:0]      ref_s_r;
  logic [2:0]      vco_s_r;
  logic [1:0]      byp_s_r;
  logic            byp_d_r;
  logic            ref_rise;
  logic            ref_any;
  logic            vco_rise;
  logic            bypass;

  logic            freq_mode_r;
  logic            coarse_r;
  logic [2:0]      fb_sel_r;
  logic [4:0]      m_r;
  logic [4:0]      n_r;
  logic [7:0]      qual_r;
  logic [3:0]      icp_r;
  logic [2:0]      res_r;
  logic [4:0]      v_r    [NOUT];
  logic [3:0]      skew_r [NOUT];
  logic            resync_r;
  logic [pll_pkg::DW-1:0] rdata_nxt;

  logic            m_tc;
  logic            n_tc;
  logic [NOUT-1:0] v_tc;
  logic [NOUT-1:0] v_lvl;
  logic            m_ev;
  logic            v_ev;
  logic            fb_ev;
  pll_pkg::lock_cfg_t  lcfg;
  pll_pkg::lock_stat_t lstat;

  // clips a write to the highest legal code, keeping unused codes unreachable
  function automatic logic [3:0] clip4(input logic [3:0] v, input logic [3:0] mx);
    clip4 = (v > mx) ? mx : v;
  endfunction

  function automatic logic is_wr(input logic [pll_pkg::AW-1:0] a,
                                 input logic [pll_pkg::AW-1:0] o);
    is_wr = WR && (a == o);
  endfunction

  // pins cross two flops; the edge detect reads only the second and later stages
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ref_s_r <= '0;
      vco_s_r <= '0;
      byp_s_r <= '0;
      byp_d_r <= 1'b0;
    end else begin
      ref_s_r <= {ref_s_r[1:0], REF_CLK};
      vco_s_r <= {vco_s_r[1:0], VCO_CLK};
      byp_s_r <= {byp_s_r[0], BYPASS};
      byp_d_r <= byp_s_r[1];
    end
  end

  assign ref_rise = ref_s_r[1] & ~ref_s_r[2];
  assign ref_any  = ref_s_r[1] ^ ref_s_r[2];
  assign vco_rise = vco_s_r[1] & ~vco_s_r[2];
  assign bypass   = byp_s_r[1];

  // control register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      freq_mode_r <= pll_pkg::CTRL_RST[pll_pkg::CTRL_FREQ_B];
      coarse_r    <= pll_pkg::CTRL_RST[pll_pkg::CTRL_COARSE_B];
      fb_sel_r    <= pll_pkg::CTRL_RST[pll_pkg::CTRL_FBSEL_LO +: 3];
    end else if (is_wr(ADDR, pll_pkg::OFF_CTRL)) begin
      freq_mode_r <= WDATA[pll_pkg::CTRL_FREQ_B];
      coarse_r    <= WDATA[pll_pkg::CTRL_COARSE_B];
      if (WDATA[pll_pkg::CTRL_FBSEL_LO +: 3] <= pll_pkg::FBSEL_MAX) begin
        fb_sel_r <= WDATA[pll_pkg::CTRL_FBSEL_LO +: 3];
      end
    end
  end

  // prescalers and qualification count
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      m_r    <= pll_pkg::MDIV_RST;
      n_r    <= pll_pkg::NDIV_RST;
      qual_r <= pll_pkg::QUAL_RST;
    end else begin
      if (is_wr(ADDR, pll_pkg::OFF_MDIV)) begin
        m_r <= WDATA[4:0];
      end
      if (is_wr(ADDR, pll_pkg::OFF_NDIV)) begin
        n_r <= WDATA[4:0];
      end
      if (is_wr(ADDR, pll_pkg::OFF_QUAL)) begin
        qual_r <= (WDATA[7:0] < pll_pkg::QUAL_MIN) ? pll_pkg::QUAL_MIN : WDATA[7:0];
      end
    end
  end

  // loop filter selection
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      icp_r <= pll_pkg::ICP_RST;
      res_r <= pll_pkg::RES_RST;
    end else if (is_wr(ADDR, pll_pkg::OFF_FILT)) begin
      icp_r <= clip4(WDATA[3:0], pll_pkg::ICP_MAX);
      res_r <= 3'(clip4({1'b0, WDATA[pll_pkg::FILT_RES_LO +: 3]}, {1'b0, pll_pkg::RES_MAX}));
    end
  end

  // output divider ratios and skew
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NOUT; i++) begin
        v_r[i]    <= pll_pkg::VDIV_RST;
        skew_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        if (is_wr(ADDR, pll_pkg::OFF_VDIV0 + 4'(i))) begin
          v_r[i]    <= WDATA[4:0];
          skew_r[i] <= WDATA[pll_pkg::VDIV_SKEW_LO +: 4];
        end
      end
    end
  end

  // a control, prescaler or output divider write (not QUAL or FILT) or bypass change restarts every divider together one cycle later
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      resync_r <= 1'b1;
    end else begin
      resync_r <= (WR && ADDR != pll_pkg::OFF_QUAL && ADDR != pll_pkg::OFF_FILT &&
                   ADDR < pll_pkg::OFF_STAT) || (bypass != byp_d_r);
    end
  end

  // read port
  always_comb begin
    rdata_nxt = '0;
    case (ADDR)
      pll_pkg::OFF_CTRL: begin
        rdata_nxt[pll_pkg::CTRL_FREQ_B]        = freq_mode_r;
        rdata_nxt[pll_pkg::CTRL_COARSE_B]      = coarse_r;
        rdata_nxt[pll_pkg::CTRL_FBSEL_LO +: 3] = fb_sel_r;
      end
      pll_pkg::OFF_MDIV: rdata_nxt[4:0] = m_r;
      pll_pkg::OFF_NDIV: rdata_nxt[4:0] = n_r;
      pll_pkg::OFF_QUAL: rdata_nxt[7:0] = qual_r;
      pll_pkg::OFF_FILT: begin
        rdata_nxt[3:0]                        = icp_r;
        rdata_nxt[pll_pkg::FILT_RES_LO +: 3]  = res_r;
      end
      pll_pkg::OFF_STAT: rdata_nxt[2:0] = {bypass, lstat.ref_lost, lstat.locked};
      default: begin
        for (int i = 0; i < NOUT; i++) begin
          if (ADDR == pll_pkg::OFF_VDIV0 + 4'(i)) begin
            rdata_nxt[4:0]                       = v_r[i];
            rdata_nxt[pll_pkg::VDIV_SKEW_LO +: 4] = skew_r[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? rdata_nxt : '0;
    end
  end

  // bypass routes prescaled reference
  // both reference edges count in bypass, which gives the halved ratios
  assign m_ev = bypass ? ref_any : ref_rise;
  assign v_ev = bypass ? m_tc : vco_rise;

  edge_div #(.W(5), .DLW(6)) u_mdiv (
    .clk       (CLK),
    .rst       (RST),
    .sync_clr  (resync_r),
    .ratio_m1  (m_r),
    .start_dly (6'h00),
    .ev        (m_ev),
    .tc        (m_tc),
    .lvl       ()
  );

  // halved in bypass through edge doubling
  for (genvar g = 0; g < NOUT; g++) begin : g_vdiv
    logic [5:0] dly;
    assign dly = bypass ? 6'h00 : (coarse_r ? {1'b0, skew_r[g], 1'b0} : {2'b00, skew_r[g]});
    edge_div #(.W(5), .DLW(6)) u_vdiv (
      .clk       (CLK),
      .rst       (RST),
      .sync_clr  (resync_r),
      .ratio_m1  (v_r[g]),
      .start_dly (dly),
      .ev        (v_ev),
      .tc        (v_tc[g]),
      .lvl       (v_lvl[g])
    );
  end

  assign fb_ev = v_tc[fb_sel_r] & v_lvl[fb_sel_r];

  edge_div #(.W(5), .DLW(6)) u_ndiv (
    .clk       (CLK),
    .rst       (RST),
    .sync_clr  (resync_r),
    .ratio_m1  (n_r),
    .start_dly (6'h00),
    .ev        (fb_ev),
    .tc        (n_tc),
    .lvl       ()
  );

  assign lcfg.freq_mode = freq_mode_r;
  assign lcfg.enable    = ~bypass;
  assign lcfg.qual_m1   = qual_r;

  lock_det u_lock (
    .clk    (CLK),
    .rst    (RST),
    .cfg    (lcfg),
    .ref_ev (m_tc),
    .fb_ev  (n_tc),
    .stat   (lstat)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LOCK_N  <= 1'b1;
      CLK_OUT <= '0;
      CP_SEL  <= pll_pkg::ICP_RST;
      RES_SEL <= pll_pkg::RES_RST;
    end else begin
      LOCK_N  <= ~lstat.locked;
      CLK_OUT <= v_lvl;
      CP_SEL  <= icp_r;
      RES_SEL <= res_r;
    end
  end

endmodule

/* File: pll_lock_sva.sv */
// checker: port-level properties of the divider and lock block
// assumes one clock domain and the register map of the package
module pll_lock_sva #(
  parameter int NOUT = 5
) (
  // clock and reset
  input wire logic                   CLK,
  input wire logic                   RST,
  // register port
  input wire logic [pll_pkg::AW-1:0] ADDR,
  input wire logic [pll_pkg::DW-1:0] WDATA,
  input wire logic                   WR,
  input wire logic                   RD,
  input wire logic [pll_pkg::DW-1:0] RDATA,
  // pins
  input wire logic                   REF_CLK,
  input wire logic                   VCO_CLK,
  input wire logic                   BYPASS,
  input wire logic [NOUT-1:0]        CLK_OUT,
  input wire logic                   LOCK_N,
  input wire logic [3:0]             CP_SEL,
  input wire logic [2:0]             RES_SEL
);
  logic       freq_r;
  logic       ref_q_r;
  logic [8:0] still_r;
  logic [3:0] cp_exp;
  logic [2:0] res_exp;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  assign cp_exp  = (WDATA[3:0] > pll_pkg::ICP_MAX) ? pll_pkg::ICP_MAX : WDATA[3:0];
  assign res_exp = (WDATA[6:4] > pll_pkg::RES_MAX) ? pll_pkg::RES_MAX : WDATA[6:4];
  // mode mirror, so the reference-loss check covers phase mode only
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      freq_r <= 1'b0;
    end else if (WR && ADDR == pll_pkg::OFF_CTRL) begin
      freq_r <= WDATA[pll_pkg::CTRL_FREQ_B];
    end
  end
  // cycles since the reference pin last moved, saturating
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ref_q_r <= 1'b0;
      still_r <= 9'h000;
    end else begin
      ref_q_r <= REF_CLK;
      if (REF_CLK != ref_q_r) begin
        still_r <= 9'h000;
      end else if (still_r != 9'h1FF) begin
        still_r <= still_r + 9'h001;
      end
    end
  end
  a_lock_status: assert property (RD && ADDR == pll_pkg::OFF_STAT |=> RDATA[0] == !LOCK_N)
    else $error("status lock bit disagrees with lock pin");
  a_qual_range: assert property (RD && ADDR == pll_pkg::OFF_QUAL |=>
    RDATA[7:0] >= pll_pkg::QUAL_MIN && RDATA[15:8] == 8'h00)
    else $error("qualification count out of range");
  a_ref_loss: assert property (!freq_r && still_r == 9'd220 |-> LOCK_N)
    else $error("lock held without reference in phase mode");
  a_cp_clip: assert property (WR && ADDR == pll_pkg::OFF_FILT |->
    ##2 CP_SEL == $past(cp_exp, 2))
    else $error("current code wrong after filter write");
  a_res_clip: assert property (WR && ADDR == pll_pkg::OFF_FILT |->
    ##2 RES_SEL == $past(res_exp, 2))
    else $error("resistor code wrong after filter write");
  a_bypass_unlock: assert property (BYPASS [*6] |-> LOCK_N)
    else $error("lock shown in bypass");
  a_lock_cause: assert property ($fell(LOCK_N) |-> !BYPASS)
    else $error("lock asserted while bypass selected");
  a_unmapped_zero: assert property (RD && ADDR > pll_pkg::OFF_STAT |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind pll_divider_lock_detect pll_lock_sva #(.NOUT(NOUT)) pll_lock_sva_i (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .REF_CLK(REF_CLK), .VCO_CLK(VCO_CLK), .BYPASS(BYPASS), .CLK_OUT(CLK_OUT),
  .LOCK_N(LOCK_N), .CP_SEL(CP_SEL), .RES_SEL(RES_SEL));

/* File: ref_vco_model.sv */
// partner: reference source and oscillator stand-in on the system clock
// assumes the bench sets rate, phase and run state between tests
module ref_vco_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench controls
  input  wire logic run,
  input  wire logic fast,
  input  wire logic inv,
  // pins
  output logic      ref_clk,
  output logic      vco_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // reference period 16 clocks, or 8 clocks (the oscillator period) when fast
  assign ref_clk = run & ((fast ? cnt_r[2] : cnt_r[3]) ^ inv);
  // oscillator runs free; a stopped reference stands low like a gated source
  assign vco_clk = ~cnt_r[2];
endmodule

/* File: pll_divider_lock_detect_bench.sv */
// bench: register-driven tests of the divider and lock block
// assumes the partner model supplies the reference and oscillator pins
module pll_divider_lock_detect_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, wr, rd, bypass, ref_clk, vco_clk, lock_n;
  logic        ref_run, ref_fast, ref_inv;
  logic [3:0]  addr, cp_sel;
  logic [15:0] wdata, rdata, rv;
  logic [4:0]  clk_out;
  logic [2:0]  res_sel;
  int          num_errors, check_count, n, d, cnt[6];
  int          vf[5] = '{0, 1, 3, 7, 31};

  pll_divider_lock_detect #(.NOUT(5)) pll_divider_lock_detect_i (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .REF_CLK(ref_clk), .VCO_CLK(vco_clk), .BYPASS(bypass), .CLK_OUT(clk_out),
    .LOCK_N(lock_n), .CP_SEL(cp_sel), .RES_SEL(res_sel));
  ref_vco_model ref_vco_model_i (.clk(clk), .rst(rst), .run(ref_run), .fast(ref_fast),
    .inv(ref_inv), .ref_clk(ref_clk), .vco_clk(vco_clk));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // edge counts over a window may be off by one at either end
  task automatic near(input int seen, input int exp);
    check(16'((seen >= exp - 1 && seen <= exp + 1) ? exp : seen), 16'(exp));
  endtask
  task automatic wrt(input logic [3:0] a, input logic [15:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
    @(posedge clk);
    check(rv, exp);
  endtask
  task automatic setv(input int k, input logic [4:0] f, input logic [3:0] s);
    wrt(pll_pkg::OFF_VDIV0 + 4'(k), {4'h0, s, 3'h0, f});
  endtask
  task automatic wait_lock(input logic v, input int lim, input bit chk);
    n = 0;
    #1;
    while (lock_n !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (chk) check({15'h0, lock_n}, {15'h0, v});
  endtask
  task automatic count(input int lim);
    logic [5:0] p, c;
    cnt = '{default: 0};
    #1 p = {ref_clk, clk_out};
    repeat (lim) begin
      @(posedge clk);
      #1 c = {ref_clk, clk_out};
      for (int i = 0; i < 6; i++) cnt[i] += int'(c[i] & !p[i]);
      p = c;
    end
  endtask
  task automatic skew(input int exp);
    int t0, t1;
    logic [1:0] p;
    t0 = -1;
    t1 = -1;
    repeat (3) @(posedge clk);
    #1 p = clk_out[1:0];
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      #1;
      if (clk_out[0] && !p[0] && t0 < 0) t0 = i;
      if (clk_out[1] && !p[1] && t1 < 0) t1 = i;
      p = clk_out[1:0];
    end
    check(16'(t1 - t0), 16'(exp));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    bypass = 1'b0;
    ref_run = 1'b1;
    ref_fast = 1'b0;
    ref_inv = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(pll_pkg::OFF_CTRL, 16'h0000);
    rdc(pll_pkg::OFF_QUAL, 16'h000F);
    wrt(pll_pkg::OFF_QUAL, 16'h0000);
    rdc(pll_pkg::OFF_QUAL, 16'h000F);
    wrt(pll_pkg::OFF_QUAL, 16'h00FF);
    rdc(pll_pkg::OFF_QUAL, 16'h00FF);
    wrt(pll_pkg::OFF_QUAL, 16'h000F);
    wrt(4'hB, 16'hFFFF);
    rdc(4'hB, 16'h0000);
    wrt(pll_pkg::OFF_CTRL, 16'h0008);
    wrt(pll_pkg::OFF_CTRL, 16'h001C);
    rdc(pll_pkg::OFF_CTRL, 16'h0008);
    wrt(pll_pkg::OFF_MDIV, 16'h001F);
    rdc(pll_pkg::OFF_MDIV, 16'h001F);
    wrt(pll_pkg::OFF_NDIV, 16'h001F);
    rdc(pll_pkg::OFF_NDIV, 16'h001F);
    wrt(pll_pkg::OFF_MDIV, 16'h0000);
    wrt(pll_pkg::OFF_NDIV, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      wrt(pll_pkg::OFF_FILT, 16'(i * 17));
      @(posedge clk);
      check(16'(cp_sel), 16'(i > 13 ? 13 : i));
      check(16'(res_sel), 16'(i % 8 > 5 ? 5 : i % 8));
    end
    $display("test registers done");
    for (int k = 0; k < 5; k++) setv(k, 5'(vf[k]), 4'h0);
    count(2048);
    for (int k = 0; k < 5; k++) near(cnt[k], 2048 / (16 * (vf[k] + 1)));
    for (int k = 0; k < 5; k++) setv(k, 5'h01, 4'h0);
    d = 0;
    repeat (400) begin
      @(posedge clk);
      #1 d += int'(clk_out != {5{clk_out[0]}});
    end
    check(16'(d), 16'h0000);
    setv(0, 5'h03, 4'h0);
    setv(1, 5'h03, 4'h3);
    skew(3 * 8);
    // coarse run stays out of lock, so the filter is untouched
    wrt(pll_pkg::OFF_CTRL, 16'h0002);
    skew(2 * 3 * 8);
    $display("test dividers done");
    setv(0, 5'h00, 4'h0);
    setv(1, 5'h01, 4'h0);
    wrt(pll_pkg::OFF_CTRL, 16'h0001);
    wait_lock(1'b0, 1500, 1);
    check(16'(n >= 240), 16'h0001);
    rdc(pll_pkg::OFF_STAT, 16'h0001);
    count(2048);
    near(cnt[1], cnt[5] * 1 * 2 / (1 * 4));
    ref_fast <= 1'b1;
    wait_lock(1'b1, 80, 1);
    wrt(pll_pkg::OFF_MDIV, 16'h0001);
    for (int s = 1; s < 5; s++) begin
      wrt(pll_pkg::OFF_CTRL, 16'(s * 4 + 1));
      wait_lock(1'b1, 200, 1);
      for (int k = 0; k < 5; k++) setv(k, 5'(k != s), 4'h0);
      wait_lock(1'b0, 1500, 1);
    end
    ref_run <= 1'b0;
    repeat (500) @(posedge clk);
    #1 check({15'h0, lock_n}, 16'h0000);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check({15'h0, lock_n}, 16'h0001);
    @(posedge clk);
    rst <= 1'b0;
    ref_run <= 1'b1;
    ref_fast <= 1'b0;
    @(posedge clk);
    rdc(pll_pkg::OFF_QUAL, 16'h000F);
    $display("test frequency lock done");
    for (int i = 0; i < 2 && lock_n !== 1'b0; i++) begin
      ref_inv <= 1'(i);
      wait_lock(1'b0, 300, 0);
    end
    check({15'h0, lock_n}, 16'h0000);
    check(16'(n <= 100), 16'h0001);
    ref_run <= 1'b0;
    wait_lock(1'b1, 260, 1);
    ref_run <= 1'b1;
    $display("test phase lock done");
    bypass <= 1'b1;
    repeat (20) @(posedge clk);
    #1 check({15'h0, lock_n}, 16'h0001);
    rdc(pll_pkg::OFF_STAT, 16'h0004);
    count(320);
    near(cnt[0], cnt[5]);
    setv(0, 5'h03, 4'h0);
    setv(1, 5'h03, 4'h3);
    skew(0);
    bypass <= 1'b0;
    $display("test bypass done");
    final_report();
  end
endmodule
